// ===== design/slte_tx_encoder.sv
// Transmit character path: character FIFO, 4B/5B and 5B/6B encoder, NRZI serializer.
`default_nettype none

module slte_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             clear_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             not_full_q;
  wire              push_w = in_valid_i && not_full_q;
  wire              pop_w  = out_ready_i && (cnt_q != '0);

  assign cnt_d       = cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
  assign in_ready_o  = not_full_q;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem[rd_q];

  always_ff @(posedge ref_clk_i) begin
    if (push_w) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || clear_i) begin
      wr_q       <= '0;
      rd_q       <= '0;
      cnt_q      <= '0;
      not_full_q <= 1'b1;
    end else begin
      wr_q       <= push_w ? AW'(wr_q + 1'b1) : wr_q;
      rd_q       <= pop_w ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q      <= cnt_d;
      not_full_q <= cnt_d != (AW+1)'(DEPTH);
    end
  end
endmodule

module slte_tx_encoder #(
  parameter int FIFO_DEPTH = slte_pkg::SLTE_FIFO_D
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Static mode selection
  input  wire logic        fifo_bypass_select_i,
  input  wire logic        encoder_bypass_select_i,
  input  wire logic        char_width_select_i,
  input  wire logic [1:0]  bit_rate_select_i,
  // Parallel character input
  input  wire logic [11:0] tx_char_input_i,
  input  wire logic [3:0]  tx_command_bus_i,
  input  wire logic        tx_special_select_i,
  input  wire logic        tx_violation_send_i,
  input  wire logic        tx_char_strobe_i,
  input  wire logic        tx_fifo_clear_i,
  input  wire logic        tx_pause_request_i,
  // Status toward the host
  output logic             tx_char_taken_o,
  output logic             tx_fifo_ready_o,
  output logic             tx_sync_mode_o,
  // Serial line
  output logic             serial_line_out_p_o,
  output logic             serial_line_out_n_o
);
  localparam int W = slte_pkg::SLTE_WORD_W;

  slte_pkg::slte_mode_t mode_q;
  logic [1:0]  rate_q;
  logic [2:0]  div_q;
  logic [3:0]  cnt_q;
  logic [11:0] sh_q;
  logic        line_q;
  logic        line_n_q;
  logic        taken_q;
  logic        ready_q;
  logic        sync_q;

  // Mode decode from the pins; it takes effect only at a pair boundary.
  wire         sync_w   = !fifo_bypass_select_i;
  wire         pre_w    = encoder_bypass_select_i;
  wire         w8_w     = char_width_select_i;
  slte_pkg::slte_mode_t mode_w;
  assign mode_w = sync_w ? (pre_w ? slte_pkg::SLTE_SYNC_PRE : slte_pkg::SLTE_SYNC_ENC)
                         : (pre_w ? slte_pkg::SLTE_ASYN_PRE : slte_pkg::SLTE_ASYN_ENC);

  // Bit enable divider; the 2.5x rate is refused in synchronous modes.
  wire         in_sync  = mode_q inside {slte_pkg::SLTE_SYNC_ENC, slte_pkg::SLTE_SYNC_PRE};
  wire [2:0]   div_max  = (rate_q == slte_pkg::SLTE_RATE_X10) ? slte_pkg::SLTE_DIV_X10 :
                          (rate_q == slte_pkg::SLTE_RATE_X5 || in_sync) ? slte_pkg::SLTE_DIV_X5 :
                          slte_pkg::SLTE_DIV_X25;
  wire         bit_en   = div_q == 3'h1;
  wire         load_w   = bit_en && (cnt_q <= 4'h1);

  // Character word and FIFO; the FIFO is filled only in asynchronous modes.
  wire [W-1:0] in_word  = {tx_violation_send_i, tx_special_select_i, tx_command_bus_i, tx_char_input_i};
  logic        f_vld;
  logic        f_rdy;
  logic [W-1:0] f_word;
  wire         f_clr    = !in_sync && tx_fifo_clear_i;
  wire         f_push   = !in_sync && tx_char_strobe_i;
  wire         f_pop    = load_w && !sync_w && !tx_pause_request_i;

  slte_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .clear_i    (f_clr),
    .in_valid_i (f_push),
    .in_ready_o (f_rdy),
    .in_data_i  (in_word),
    .out_valid_o(f_vld),
    .out_ready_i(f_pop),
    .out_data_o (f_word)
  );

  // Source of the next pair: the host directly in synchronous modes, the FIFO head otherwise.
  wire [W-1:0] src_w    = sync_w ? in_word : f_word;
  wire         src_vld  = sync_w ? tx_char_strobe_i : (f_vld && !tx_pause_request_i);
  wire [11:0]  dat_w    = src_w[11:0];
  wire [3:0]   cmd_w    = src_w[slte_pkg::SLTE_POS_CMD +: 4];
  wire         spec_w   = src_w[slte_pkg::SLTE_POS_SPEC];
  wire         viol_w   = src_w[slte_pkg::SLTE_POS_VIOL];

  // Data and command symbol pairs, high symbol leftmost.
  wire [11:0]  d8_pair  = {slte_pkg::SLTE_ENC5[dat_w[7:4]], slte_pkg::SLTE_ENC5[dat_w[3:0]], 2'h0};
  wire [11:0]  d10_pair = {slte_pkg::SLTE_ENC6[dat_w[9:5]], slte_pkg::SLTE_ENC6[dat_w[4:0]]};
  wire [11:0]  c8_pair  = {slte_pkg::SLTE_CMD8[cmd_w], 2'h0};
  wire [11:0]  c10_pair = slte_pkg::SLTE_CMD10[cmd_w[1:0]];
  wire [11:0]  s_pair   = w8_w ? {slte_pkg::SLTE_SYNC8_PAIR, 2'h0} : slte_pkg::SLTE_SYNC10_PAIR;
  wire [11:0]  v_pair   = w8_w ? {slte_pkg::SLTE_VIOL8_PAIR, 2'h0} : slte_pkg::SLTE_VIOL10_PAIR;
  wire [11:0]  enc_pair = spec_w ? (w8_w ? c8_pair : c10_pair)
                                 : (w8_w ? d8_pair : d10_pair);

  // Pre-encoded characters leave least significant bit first, so they are reversed here.
  logic [11:0] rev_w;
  always_comb begin
    rev_w = '0;
    for (int i = 0; i < 12; i++) begin
      rev_w[11-i] = dat_w[i];
    end
  end

  // The special select is not looked at in pre-encoded modes.
  wire [11:0]  pair_w   = !src_vld ? s_pair :
                          pre_w    ? rev_w :
                          viol_w   ? v_pair : enc_pair;
  wire [3:0]   len_w    = w8_w ? slte_pkg::SLTE_LEN_8 : slte_pkg::SLTE_LEN_10;

  // Shifter, bit counter and mode latch; the mode is caught only when a new pair loads.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      mode_q <= slte_pkg::SLTE_SYNC_ENC;
      rate_q <= slte_pkg::SLTE_RATE_X10;
      div_q  <= 3'h1;
      cnt_q  <= 4'h0;
      sh_q   <= 12'h000;
    end else begin
      div_q <= bit_en ? div_max : 3'(div_q - 1'b1);
      if (load_w) begin
        mode_q <= mode_w;
        rate_q <= bit_rate_select_i;
        cnt_q  <= len_w;
        sh_q   <= pair_w;
      end else if (bit_en) begin
        cnt_q <= 4'(cnt_q - 1'b1);
        sh_q  <= {sh_q[10:0], 1'b0};
      end
    end
  end

  // NRZI line: a one toggles the line, a zero holds it.
  // The complement has a flop of its own so that both line outputs switch on the same edge.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      line_q   <= 1'b0;
      line_n_q <= 1'b1;
    end else if (bit_en && cnt_q != 4'h0 && sh_q[11]) begin
      line_q   <= !line_q;
      line_n_q <= line_q;
    end
  end

  // Host handshake status.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      taken_q <= 1'b0;
      ready_q <= 1'b0;
      sync_q  <= 1'b1;
    end else begin
      taken_q <= sync_w ? (load_w && tx_char_strobe_i) : (f_push && f_rdy);
      ready_q <= !in_sync && f_rdy && !f_clr;
      sync_q  <= in_sync;
    end
  end

  assign tx_char_taken_o     = taken_q;
  assign tx_fifo_ready_o     = ready_q;
  assign tx_sync_mode_o      = sync_q;
  assign serial_line_out_p_o = line_q;
  assign serial_line_out_n_o = line_n_q;

  // Checks on the shifter and the character path.
  property p_sync_fill;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !tx_char_strobe_i && w8_w) |=> (sh_q == {slte_pkg::SLTE_SYNC8_PAIR, 2'h0});
  endproperty
  a_sync_fill: assert property (p_sync_fill) else $error("Sync fill pair not loaded.");

  property p_take;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && tx_char_strobe_i) |=> tx_char_taken_o;
  endproperty
  a_take: assert property (p_take) else $error("Strobed character not taken at its slot.");

  property p_no_fifo_sync;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (in_sync && tx_char_strobe_i) |=> (u_fifo.cnt_q == $past(u_fifo.cnt_q)) || $past(f_pop);
  endproperty
  a_no_fifo_sync: assert property (p_no_fifo_sync) else $error("FIFO filled in synchronous mode.");

  property p_pause;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (!in_sync && tx_pause_request_i && !f_clr) |=> (u_fifo.rd_q == $past(u_fifo.rd_q));
  endproperty
  a_pause: assert property (p_pause) else $error("FIFO drained while paused.");

  property p_mode_stable;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !load_w |=> $stable(mode_q);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("Mode changed inside a pair.");

  property p_len;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      load_w |=> (cnt_q == ($past(w8_w) ? slte_pkg::SLTE_LEN_8 : slte_pkg::SLTE_LEN_10)) ##1 (cnt_q <= $past(cnt_q));
  endproperty
  a_len: assert property (p_len) else $error("Pair length wrong for width.");

  property p_nrzi;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (bit_en && cnt_q != 4'h0) |=> (serial_line_out_p_o != $past(serial_line_out_p_o)) == $past(sh_q[11]);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("Line toggle does not match bit.");

  property p_rate10;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (rate_q == slte_pkg::SLTE_RATE_X10 && bit_en && !load_w) |=> bit_en;
  endproperty
  a_rate10: assert property (p_rate10) else $error("Bit enable missing at full rate.");

  property p_rate5_sync;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (in_sync && rate_q != slte_pkg::SLTE_RATE_X10 && bit_en && !load_w) |=> !bit_en ##1 bit_en;
  endproperty
  a_rate5_sync: assert property (p_rate5_sync) else $error("Synchronous half rate wrong.");

  property p_cmd8;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !pre_w && w8_w && tx_char_strobe_i && tx_special_select_i
       && !tx_violation_send_i && tx_command_bus_i == 4'h1) |=> (sh_q == 12'hffc);
  endproperty
  a_cmd8: assert property (p_cmd8) else $error("Idle command pair wrong.");

  property p_bypass_spec;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && pre_w && tx_char_strobe_i)
        |=> (sh_q == $past(rev_w)) && (sh_q[11] == $past(tx_char_input_i[0]));
  endproperty
  a_bypass_spec: assert property (p_bypass_spec) else $error("Pre-encoded word altered.");

  property p_line_pair;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      serial_line_out_n_o == !serial_line_out_p_o;
  endproperty
  a_line_pair: assert property (p_line_pair) else $error("Line outputs not complementary.");

  property p_async_take;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (!in_sync && fifo_bypass_select_i && tx_char_strobe_i) |=> (tx_char_taken_o == $past(f_rdy));
  endproperty
  a_async_take: assert property (p_async_take) else $error("Buffered push acknowledge wrong.");

  property p_sync_ready;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      in_sync |=> !tx_fifo_ready_o;
  endproperty
  a_sync_ready: assert property (p_sync_ready) else $error("FIFO ready shown in synchronous mode.");

  property p_sync_clear;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (in_sync && tx_fifo_clear_i) |=> (u_fifo.wr_q == $past(u_fifo.wr_q));
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("FIFO clear acted in synchronous mode.");

  property p_sync10_fill;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !tx_char_strobe_i && !w8_w) |=> (sh_q == slte_pkg::SLTE_SYNC10_PAIR);
  endproperty
  a_sync10_fill: assert property (p_sync10_fill) else $error("Wide sync fill pair not loaded.");

  property p_viol8;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !pre_w && w8_w && tx_char_strobe_i && tx_violation_send_i)
        |=> (sh_q == {slte_pkg::SLTE_VIOL8_PAIR, 2'h0});
  endproperty
  a_viol8: assert property (p_viol8) else $error("Narrow violation pair wrong.");

  property p_viol10;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !pre_w && !w8_w && tx_char_strobe_i && tx_violation_send_i)
        |=> (sh_q == slte_pkg::SLTE_VIOL10_PAIR);
  endproperty
  a_viol10: assert property (p_viol10) else $error("Wide violation pair wrong.");

  property p_data8;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !pre_w && w8_w && tx_char_strobe_i && !tx_special_select_i
       && !tx_violation_send_i && tx_char_input_i[7:0] == 8'hf0) |=> (sh_q == 12'hef8);
  endproperty
  a_data8: assert property (p_data8) else $error("Data character pair wrong.");

  property p_cmd10;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (load_w && sync_w && !pre_w && !w8_w && tx_char_strobe_i && tx_special_select_i
       && !tx_violation_send_i && tx_command_bus_i[1:0] == 2'h0) |=> (sh_q == 12'h623);
  endproperty
  a_cmd10: assert property (p_cmd10) else $error("Wide sync command pair wrong.");

  c_sync_data:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) load_w && sync_w && tx_char_strobe_i);
  c_fifo_full:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) !in_sync && !f_rdy);
  c_cmd10:      cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) load_w && !w8_w && spec_w && src_vld);
  c_async_fill: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) load_w && !sync_w && !f_vld);
  c_rate_half:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
                                load_w && in_sync && rate_q != slte_pkg::SLTE_RATE_X10);
endmodule
`default_nettype wire

// ===== shared/slte_pkg.sv
// Constants, symbol tables and mode encodings for the serial link transmit character encoder.
// Overview of operation
// - Characters pass FIFO, encoder, then shift out on the serial line.
// - Bit rate is the reference rate times 2.5, 5 or 10.
// - Parallel side takes 8/10-bit characters or 10/12-bit pre-encoded characters per mode.
// - With the encoder bypassed the special select input is ignored.
// - Mode comes from static FIFO-bypass, encoder-bypass and width select inputs.
// - Synchronous modes are used only while FIFO bypass select is low.
// - Synchronous encoded mode skips the FIFO but keeps the encoder.
// - Synchronous encoded mode captures one character per character slot into the encoder.
// - Synchronous mode serialises at the reference rate times 10 or 5.
// - Synchronous encoded mode ignores FIFO clear and pause inputs.
// - Without strobe the encoder is loaded with the sync pair of the width.
// - Encoded character is violation bit, data bits and special select bit.
// - Special select low encodes the data bus with data symbol codes.
// - Special select high encodes the command bus with special symbol codes.
// - 8-bit command codes map to fixed 5-bit symbol pairs, 0 sync, 1 idle.
// - 10-bit command codes map to fixed 6-bit symbol pairs, 0 sync.
// - Encoded symbols go out most significant bit first, high symbol first.
// - Command field is four bits in 8-bit mode, two bits in 10-bit mode.
`default_nettype none
package slte_pkg;
  // Bit rate selection, multiplier relative to the character reference rate.
  localparam logic [1:0] SLTE_RATE_X10 = 2'h0;
  localparam logic [1:0] SLTE_RATE_X5  = 2'h1;
  localparam logic [1:0] SLTE_RATE_X25 = 2'h2;
  localparam logic [2:0] SLTE_DIV_X10  = 3'h1;
  localparam logic [2:0] SLTE_DIV_X5   = 3'h2;
  localparam logic [2:0] SLTE_DIV_X25  = 3'h4;
  // Symbol pair lengths in bits.
  localparam logic [3:0] SLTE_LEN_8    = 4'ha;
  localparam logic [3:0] SLTE_LEN_10   = 4'hc;
  // Stored character word field positions.
  localparam int SLTE_WORD_W   = 18;
  localparam int SLTE_POS_VIOL = 17;
  localparam int SLTE_POS_SPEC = 16;
  localparam int SLTE_POS_CMD  = 12;
  localparam int SLTE_FIFO_D   = 32;
  // Fill and violation pairs, left justified where shorter than twelve bits.
  localparam logic [9:0]  SLTE_SYNC8_PAIR  = 10'h311;
  localparam logic [11:0] SLTE_SYNC10_PAIR = 12'h623;
  localparam logic [9:0]  SLTE_VIOL8_PAIR  = 10'h3e0;
  localparam logic [11:0] SLTE_VIOL10_PAIR = 12'hfc0;
  localparam logic [4:0] SLTE_ENC5 [0:15] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [5:0] SLTE_ENC6 [0:31] = '{
    6'h26, 6'h2c, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
    6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
    6'h3e, 6'h19, 6'h29, 6'h2d, 6'h1a, 6'h1b, 6'h1e, 6'h1f,
    6'h2a, 6'h2b, 6'h2e, 6'h2f, 6'h3a, 6'h3b, 6'h3c, 6'h3d};
  localparam logic [9:0] SLTE_CMD8 [0:15] = '{
    10'h311, 10'h3ff, 10'h1ad, 10'h1b9, 10'h3e4, 10'h1a7, 10'h327, 10'h339,
    10'h084, 10'h09f, 10'h080, 10'h0e7, 10'h0f9, 10'h004, 10'h01f, 10'h000};
  localparam logic [11:0] SLTE_CMD10 [0:3] = '{12'h623, 12'hfff, 12'h75d, 12'h779};
  // Latched transmit mode, one-hot.
  typedef enum logic [3:0] {
    SLTE_SYNC_ENC = 4'h1,
    SLTE_SYNC_PRE = 4'h2,
    SLTE_ASYN_ENC = 4'h4,
    SLTE_ASYN_PRE = 4'h8
  } slte_mode_t;
endpackage
`default_nettype wire

// ===== sim/slte_host_model.sv
// Host model that offers characters on the parallel transmit side of the encoder.
`default_nettype none
module slte_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        taken_i,
  input  wire logic        async_i,
  output logic [11:0]      char_o,
  output logic [3:0]       cmd_o,
  output logic             spec_o,
  output logic             viol_o,
  output logic             strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {char_o, cmd_o, spec_o, viol_o, strobe_o} = 19'h0_0000;
  end
  // Released lines show the inverse, so a stale value can never pass for a held one.
  task automatic drop;
    strobe_o = 1'b0;
    {char_o, cmd_o, spec_o, viol_o} = ~{char_o, cmd_o, spec_o, viol_o};
  endtask
  // Called just after an edge; the character is held until the encoder confirms it or 40 edges pass, and for one edge only when buffered.
  task automatic send(input logic [11:0] d, input logic [3:0] c, input logic s, input logic v,
                      output logic ok);
    ok = 1'b0;
    {char_o, cmd_o, spec_o, viol_o} = {d, c, s, v};
    strobe_o = 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge ref_clk_i);
      #1;
      ok = (taken_i === 1'b1);
      // A buffered push is offered for one edge only; a refused one is not retried.
      if (async_i) break;
    end
    #1;
    drop();
    // One edge passes before the next offer, so the strobe never rises where it just fell.
    @(posedge ref_clk_i);
    #2;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_serial_link_tx_char_encoder.sv
// Self-checking bench for the serial link transmit character encoder.
`default_nettype none
module tb_serial_link_tx_char_encoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_i, rst_b_i, fbyp, ebyp, w8, clr, pause, mon_en, ok;
  logic        taken, fready, smode, lp, ln, strobe, spec, viol;
  logic        lp_q, s_w8, s_eb, s_fb, s_sp, s_vi, s_tk, l_w8, l_fb;
  logic [1:0]  rate;
  logic [3:0]  cmd, s_cmd;
  logic [11:0] chr, s_chr, got, expv;
  logic [31:0] rng;
  logic [11:0] exp_q[$];
  int          num_errors, n_compared, pos, cyc, t0, nacc;

  slte_tx_encoder #(.FIFO_DEPTH(32)) DUT (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fifo_bypass_select_i(fbyp),
    .encoder_bypass_select_i(ebyp), .char_width_select_i(w8), .bit_rate_select_i(rate),
    .tx_char_input_i(chr), .tx_command_bus_i(cmd), .tx_special_select_i(spec),
    .tx_violation_send_i(viol), .tx_char_strobe_i(strobe), .tx_fifo_clear_i(clr),
    .tx_pause_request_i(pause), .tx_char_taken_o(taken), .tx_fifo_ready_o(fready),
    .tx_sync_mode_o(smode), .serial_line_out_p_o(lp), .serial_line_out_n_o(ln));
  slte_host_model host (
    .ref_clk_i(ref_clk_i), .taken_i(taken), .async_i(fbyp), .char_o(chr), .cmd_o(cmd),
    .spec_o(spec), .viol_o(viol), .strobe_o(strobe));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Pairs are left justified in twelve bits, first bit on the line at the top.
  function automatic logic [11:0] sync_pair(input logic w);
    return w ? 12'hc44 : 12'h623;
  endfunction
  function automatic logic [11:0] exp_pair(input logic w, input logic eb, input logic s, input logic v,
                                           input logic [11:0] d, input logic [3:0] c);
    logic [11:0] r;
    r = 12'h000;
    if (eb) begin
      for (int i = 0; i < 12; i++) r[11-i] = d[i];
      if (w) r[1:0] = 2'h0;
    end else if (v) r = w ? {slte_pkg::SLTE_VIOL8_PAIR, 2'h0} : slte_pkg::SLTE_VIOL10_PAIR;
    else if (s) r = w ? {slte_pkg::SLTE_CMD8[c], 2'h0} : slte_pkg::SLTE_CMD10[c[1:0]];
    else if (w) r = {slte_pkg::SLTE_ENC5[d[7:4]], slte_pkg::SLTE_ENC5[d[3:0]], 2'h0};
    else r = {slte_pkg::SLTE_ENC6[d[9:5]], slte_pkg::SLTE_ENC6[d[4:0]]};
    return r;
  endfunction
  task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic check_flag(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask
  task automatic put(input logic [11:0] d, input logic [3:0] c, input logic s, input logic v);
    host.send(d, c, s, v, ok);
    check_flag("taken", 1'b1, ok);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    if (n > 0) #2;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Decodes the NRZI line one pair per slot; inputs seen one sample earlier are those the load edge took.
  always begin
    @(posedge ref_clk_i);
    #1;
    cyc++;
    check_flag("line_n", ~lp, ln);
    if (rst_b_i !== 1'b1 || !mon_en) pos = -2;
    else if (pos >= 0) begin
      if (pos == 0) begin
        {l_w8, l_fb, got} = {s_w8, s_fb, 12'h000};
        expv = (s_tk | taken) ? exp_pair(s_w8, s_eb, s_sp, s_vi, s_chr, s_cmd) : sync_pair(s_w8);
      end
      got[11-pos] = lp ^ lp_q;
      if (pos == (l_w8 ? 9 : 11)) begin
        if (l_fb) expv = (got !== sync_pair(l_w8) && exp_q.size() > 0) ? exp_q.pop_front() : sync_pair(l_w8);
        check_val("pair", {4'h0, expv}, {4'h0, got});
        pos = -1;
      end
    end
    pos++;
    {lp_q, s_w8, s_eb, s_fb, s_sp, s_vi, s_tk, s_chr, s_cmd} = {lp, w8, ebyp, fbyp, spec, viol, taken, chr, cmd};
  end

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {rst_b_i, fbyp, ebyp, clr, pause} = 5'h00;
    {w8, mon_en} = 2'h3;
    rate = 2'h0;
    rng = 32'h0000_0030;
    step(2);
    rst_b_i = 1'b1;
    check_flag("sync_mode", 1'b1, smode);
    check_flag("fifo_ready", 1'b0, fready);
    for (int c = 0; c < 16; c++) begin
      host.send(12'h000, 4'(c), 1'b1, 1'b0, ok);
      check_flag("taken", 1'b1, ok);
    end
    put(12'h0ff, 4'h0, 1'b0, 1'b1);
    put(12'h0f0, 4'h5, 1'b0, 1'b0);
    w8 = 1'b0;
    for (int c = 0; c < 4; c++) put(12'hfff, 4'(c) | 4'hc, 1'b1, 1'b0);
    put(12'h3e1, 4'h0, 1'b0, 1'b0);
    ebyp = 1'b1;
    put(12'ha5c, 4'h3, 1'b1, 1'b1);
    step(30);
    // Width changes land one to eight clocks into a slot; the pair in flight must stay whole.
    for (int k = 0; k < 80; k++) begin
      rng = xs(rng);
      if (rng[3:0] == 4'h0) w8 = rng[4];
      ebyp = (rng[7:5] == 3'h0);
      {clr, pause} = rng[9:8];
      host.send(rng[31:20], rng[19:16], rng[10], rng[11] & rng[12], ok);
      check_flag("taken", 1'b1, ok);
      step(int'(rng[15:13]));
    end
    {w8, ebyp, clr, pause} = 4'h8;
    put(12'h012, 4'h0, 1'b0, 1'b0);
    mon_en = 1'b0;
    rate = 2'h1;
    // The first slot at the new rate is one clock short, as the divider reloads at the old rate.
    put(12'h034, 4'h0, 1'b0, 1'b0);
    put(12'h045, 4'h0, 1'b0, 1'b0);
    t0 = cyc;
    put(12'h056, 4'h0, 1'b0, 1'b0);
    check_val("slot_gap", 16'h0014, 16'(cyc - t0));
    {rst_b_i, rate, mon_en} = 4'h1;
    step(2);
    rst_b_i = 1'b1;
    pause = 1'b1;
    fbyp = 1'b1;
    step(12);
    check_flag("sync_mode", 1'b0, smode);
    check_flag("fifo_ready", 1'b1, fready);
    for (int k = 0; k < 34; k++) begin
      rng = xs(rng);
      host.send(rng[11:0], 4'h0, 1'b0, 1'b0, ok);
      check_flag("taken", k < 32, ok);
      if (ok) exp_q.push_back(exp_pair(1'b1, 1'b0, 1'b0, 1'b0, rng[11:0], 4'h0));
      if (ok) nacc++;
    end
    check_val("accepted", 16'h0020, 16'(nacc));
    check_flag("fifo_ready", 1'b0, fready);
    pause = 1'b0;
    for (int n = 0; n < 600 && exp_q.size() > 0; n++) step(1);
    step(12);
    check_val("left", 16'h0000, 16'(exp_q.size()));
    check_flag("fifo_ready", 1'b1, fready);
    report_and_stop();
  end
endmodule
`default_nettype wire
